// [rtl/uip_pkg.sv]
package uip_pkg;
    localparam int          NUM_SLOTS       = 32;
    localparam int          VEC_SHIFT       = 2;
    // Slot numbers of the shared sources, slot 0 is the highest priority
    localparam int          SLOT_SETUP_RDY  = 0;
    localparam int          SLOT_SOF        = 1;
    localparam int          SLOT_SETUP_TOK  = 2;
    localparam int          SLOT_SUSPEND    = 3;
    localparam int          SLOT_BUS_RESET  = 4;
    localparam int          SLOT_HIGH_SPEED = 5;
    localparam int          SLOT_CTRL_ACK   = 6;
    localparam int          SLOT_EP0_IN     = 8;
    localparam int          SLOT_IN_NAK     = 16;
    localparam int          SLOT_PING0      = 18;
    localparam int          SLOT_ERR_LIMIT  = 24;
    localparam int          SLOT_ISO_ERR0   = 28;
    // Slots 7, 17, 25, 26 and 27 are reserved and never set
    localparam logic [31:0] SLOT_USED_MASK  = 32'hF1FDFF7F;
    localparam logic [31:0] SLOT_REDUCED    = 32'h00FC0020;
    // Register map, byte wide
    localparam logic [7:0]  ADR_REQ0        = 8'h00;
    localparam logic [7:0]  ADR_EN0         = 8'h04;
    localparam logic [7:0]  ADR_VECTOR      = 8'h08;
    localparam logic [7:0]  ADR_MAIN_FLAG   = 8'h09;
    localparam logic [7:0]  ADR_MAIN_EN     = 8'h0A;
    localparam logic [7:0]  ADR_SETUP_CTRL  = 8'h0B;
    localparam logic [7:0]  ADR_FRAME_LO    = 8'h0C;
    localparam logic [7:0]  ADR_FRAME_HI    = 8'h0D;
    localparam logic [7:0]  ADR_POWER       = 8'h0E;
    localparam logic [7:0]  ADR_SETUP_BYTE0 = 8'h10;
    localparam int          MAIN_FLAG_BIT   = 4;
    localparam int          MAIN_EN_BIT     = 0;
    localparam int          AUTOVEC_BIT     = 3;
    localparam int          PWR_IDLE_BIT    = 0;
    localparam int          PWR_RESUME_BIT  = 1;
    localparam logic [15:0] JUMP_LOW_ADDR   = 16'h0045;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam int          FRAME_BITS      = 11;
    localparam int          SETUP_BYTES     = 8;

    typedef struct packed {
        logic       setup_token;
        logic       setup_done;
        logic       sof;
        logic       suspend;
        logic       bus_reset;
        logic       high_speed_entered;
        logic       control_status_acked;
        logic [7:0] ep_service;
        logic       in_bulk_nak_event;
        logic [5:0] out_ping_nak;
        logic       bus_error_limit_hit;
        logic [3:0] iso_sequence_error;
    } uip_events_s;
endpackage

// [rtl/uip_top.sv]
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module uip_top #(
    parameter bit reduced_variant = 1'b0
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata_ff,
    input  wire uip_pkg::uip_events_s usb_events,
    input  wire logic [10:0]         sof_frame_number,
    input  wire logic                setup_byte_valid,
    input  wire logic [2:0]          setup_byte_index,
    input  wire logic [7:0]          setup_byte_data,
    input  wire logic [1:0]          wake_pins,
    input  wire logic                bus_activity,
    input  wire logic [15:0]         fetch_addr,
    input  wire logic [7:0]          fetch_mem_byte,
    output logic      [7:0]          fetch_byte_ff,
    output logic                     usb_int_req_ff,
    output logic                     usb_req_pulse_ff,
    output logic                     resume_int_ff,
    output logic                     osc_run_ff,
    output logic      [7:0]          usb_vector_index_byte_ff
);

    logic [31:0] req_ff;
    logic [31:0] en_ff;
    logic [31:0] nxt_req;
    logic [31:0] evt_vec;
    logic [31:0] clr_vec;
    logic [31:0] pend;
    logic        pend_any;
    logic        pend_was_ff;
    logic        clr_seen_ff;
    logic        main_flag_ff;
    logic        main_en_ff;
    logic        autovec_en_ff;
    logic [4:0]  vector_index_field;
    logic [7:0]  vec_byte;
    logic [10:0] frame_ff;
    logic [7:0]  setup_byte_regs [8];
    logic [7:0]  setup_got_ff;
    logic        idle_ff;
    logic        resume_flag_ff;
    logic [1:0]  wake_meta_ff;
    logic [1:0]  wake_sync_ff;
    logic        act_meta_ff;
    logic        act_sync_ff;
    logic        wake_hit;
    logic        wr_main;
    logic        wr_pwr;
    logic [7:0]  nxt_rdata;

    // Map named events onto priority slots
    always_comb begin
        evt_vec = '0;
        evt_vec[uip_pkg::SLOT_SETUP_RDY] = usb_events.setup_done
            && (&setup_got_ff);
        evt_vec[uip_pkg::SLOT_SOF] = usb_events.sof;
        evt_vec[uip_pkg::SLOT_SETUP_TOK] = usb_events.setup_token;
        evt_vec[uip_pkg::SLOT_SUSPEND] = usb_events.suspend;
        evt_vec[uip_pkg::SLOT_BUS_RESET] = usb_events.bus_reset;
        evt_vec[uip_pkg::SLOT_HIGH_SPEED] = usb_events.high_speed_entered;
        evt_vec[uip_pkg::SLOT_CTRL_ACK] = usb_events.control_status_acked;
        evt_vec[uip_pkg::SLOT_EP0_IN +: 8] = usb_events.ep_service;
        evt_vec[uip_pkg::SLOT_IN_NAK] = usb_events.in_bulk_nak_event;
        evt_vec[uip_pkg::SLOT_PING0 +: 6] = usb_events.out_ping_nak;
        evt_vec[uip_pkg::SLOT_ERR_LIMIT] = usb_events.bus_error_limit_hit;
        evt_vec[uip_pkg::SLOT_ISO_ERR0 +: 4] = usb_events.iso_sequence_error;
        evt_vec = evt_vec & uip_pkg::SLOT_USED_MASK;
        if (reduced_variant) begin
            evt_vec = evt_vec & ~uip_pkg::SLOT_REDUCED;
        end
    end

    // Write-one-to-clear bytes of the request latches
    always_comb begin
        clr_vec = '0;
        if (reg_wr && reg_addr[7:2] == uip_pkg::ADR_REQ0[7:2]) begin
            clr_vec[reg_addr[1:0]*8 +: 8] = reg_wdata;
        end
        // Set beats a clear in the same cycle
        nxt_req = (req_ff & ~clr_vec) | evt_vec;
    end

    // One latch per slot; reserved slots are never set
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            req_ff <= '0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_ff <= '0;
        end else if (reg_wr && reg_addr[7:2] == uip_pkg::ADR_EN0[7:2]) begin
            en_ff[reg_addr[1:0]*8 +: 8] <= reg_wdata;
        end
    end

    // Enable gates only the request, the latch still records
    assign pend     = req_ff & en_ff;
    assign pend_any = |pend;

    // Lowest slot number wins
    always_comb begin
        vector_index_field = '0;
        for (int i = uip_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
            if (pend[i]) begin
                vector_index_field = 5'(i);
            end
        end
        vec_byte = {1'b0, vector_index_field, 2'b00};
    end

    // A clear is seen in the same cycle as its effect on the pending set
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clr_seen_ff      <= 1'b0;
            pend_was_ff      <= 1'b0;
            usb_req_pulse_ff <= 1'b0;
        end else begin
            clr_seen_ff      <= |(clr_vec & req_ff & en_ff);
            pend_was_ff      <= pend_any;
            usb_req_pulse_ff <= pend_any
                && (!pend_was_ff || clr_seen_ff);
        end
    end

    assign wr_main = reg_wr && reg_addr == uip_pkg::ADR_MAIN_FLAG;

    // Pulse sets the flag even against a clearing write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            main_flag_ff <= 1'b0;
        end else if (usb_req_pulse_ff) begin
            main_flag_ff <= 1'b1;
        end else if (wr_main && !reg_wdata[uip_pkg::MAIN_FLAG_BIT]) begin
            // Lost re-pulse if firmware clears in wrong order
            main_flag_ff <= 1'b0;
        end
    end

    // Enables and autovector select are plain read-write bits
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            main_en_ff    <= 1'b0;
            autovec_en_ff <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == uip_pkg::ADR_MAIN_EN) begin
                main_en_ff <= reg_wdata[uip_pkg::MAIN_EN_BIT];
            end
            if (reg_wr && reg_addr == uip_pkg::ADR_SETUP_CTRL) begin
                autovec_en_ff <= reg_wdata[uip_pkg::AUTOVEC_BIT];
            end
        end
    end

    // Core sees the flag only through the main enable
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            usb_int_req_ff           <= 1'b0;
            usb_vector_index_byte_ff <= uip_pkg::RESET_BYTE;
        end else begin
            usb_int_req_ff           <= main_flag_ff && main_en_ff;
            usb_vector_index_byte_ff <= vec_byte;
        end
    end

    // Substitute vector byte at the jump's low address operand
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fetch_byte_ff <= uip_pkg::RESET_BYTE;
        end else if (autovec_en_ff
                     && fetch_addr == uip_pkg::JUMP_LOW_ADDR) begin
            fetch_byte_ff <= vec_byte;
        end else begin
            fetch_byte_ff <= fetch_mem_byte;
        end
    end

    // Frame number follows every start of frame packet
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_ff <= '0;
        end else if (usb_events.sof) begin
            frame_ff <= sof_frame_number;
        end
    end

    // Byte tracking restarts on each setup token
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            setup_got_ff <= '0;
        end else if (usb_events.setup_token) begin
            setup_got_ff <= '0;
        end else if (setup_byte_valid) begin
            setup_got_ff[setup_byte_index] <= 1'b1;
        end
    end

    // Bytes land as they arrive; firmware reads after the request
    // A new setup overwrites them, hence the early token warning
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < uip_pkg::SETUP_BYTES; i++) begin
                setup_byte_regs[i] <= uip_pkg::RESET_BYTE;
            end
        end else if (setup_byte_valid) begin
            setup_byte_regs[setup_byte_index] <= setup_byte_data;
        end
    end

    // Wake inputs are asynchronous pins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wake_meta_ff <= '0;
            wake_sync_ff <= '0;
            act_meta_ff  <= 1'b0;
            act_sync_ff  <= 1'b0;
        end else begin
            wake_meta_ff <= wake_pins;
            wake_sync_ff <= wake_meta_ff;
            act_meta_ff  <= bus_activity;
            act_sync_ff  <= act_meta_ff;
        end
    end

    assign wake_hit = idle_ff && ((|wake_sync_ff) || act_sync_ff);
    assign wr_pwr   = reg_wr && reg_addr == uip_pkg::ADR_POWER;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            idle_ff        <= 1'b0;
            resume_flag_ff <= 1'b0;
        end else begin
            if (wake_hit) begin
                idle_ff <= 1'b0;
            end else if (wr_pwr && reg_wdata[uip_pkg::PWR_IDLE_BIT]) begin
                idle_ff <= 1'b1;
            end
            if (wake_hit) begin
                resume_flag_ff <= 1'b1;
            end else if (wr_pwr && reg_wdata[uip_pkg::PWR_RESUME_BIT]) begin
                resume_flag_ff <= 1'b0;
            end
        end
    end

    // Resume has its own line, independent of the shared enables
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_run_ff    <= 1'b1;
            resume_int_ff <= 1'b0;
        end else begin
            osc_run_ff    <= !idle_ff || wake_hit;
            resume_int_ff <= resume_flag_ff;
        end
    end

    // Unmapped addresses read as zero
    always_comb begin
        nxt_rdata = uip_pkg::RESET_BYTE;
        if (reg_addr[7:2] == uip_pkg::ADR_REQ0[7:2]) begin
            nxt_rdata = req_ff[reg_addr[1:0]*8 +: 8];
        end else if (reg_addr[7:2] == uip_pkg::ADR_EN0[7:2]) begin
            nxt_rdata = en_ff[reg_addr[1:0]*8 +: 8];
        end else if (reg_addr[7:3] == uip_pkg::ADR_SETUP_BYTE0[7:3]) begin
            nxt_rdata = setup_byte_regs[reg_addr[2:0]];
        end else begin
            case (reg_addr)
                uip_pkg::ADR_VECTOR: begin
                    nxt_rdata = vec_byte;
                end
                uip_pkg::ADR_MAIN_FLAG: begin
                    nxt_rdata[uip_pkg::MAIN_FLAG_BIT] = main_flag_ff;
                end
                uip_pkg::ADR_MAIN_EN: begin
                    nxt_rdata[uip_pkg::MAIN_EN_BIT] = main_en_ff;
                end
                uip_pkg::ADR_SETUP_CTRL: begin
                    nxt_rdata[uip_pkg::AUTOVEC_BIT] = autovec_en_ff;
                end
                uip_pkg::ADR_FRAME_LO: begin
                    nxt_rdata = frame_ff[7:0];
                end
                uip_pkg::ADR_FRAME_HI: begin
                    nxt_rdata = {5'h00, frame_ff[10:8]};
                end
                uip_pkg::ADR_POWER: begin
                    nxt_rdata[uip_pkg::PWR_IDLE_BIT]   = idle_ff;
                    nxt_rdata[uip_pkg::PWR_RESUME_BIT] = resume_flag_ff;
                end
                default: begin
                    nxt_rdata = uip_pkg::RESET_BYTE;
                end
            endcase
        end
    end

    // Read data holds only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_ff <= uip_pkg::RESET_BYTE;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= uip_pkg::RESET_BYTE;
        end
    end

endmodule // uip_top

`default_nettype wire

// [tb/uip_top_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module uip_chk (
    input wire logic                 clock,
    input wire logic                 sys_rst,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata_ff,
    input wire uip_pkg::uip_events_s usb_events,
    input wire logic [1:0]           wake_pins,
    input wire logic [15:0]          fetch_addr,
    input wire logic [7:0]           fetch_mem_byte,
    input wire logic [7:0]           fetch_byte_ff,
    input wire logic                 usb_int_req_ff,
    input wire logic                 usb_req_pulse_ff,
    input wire logic                 osc_run_ff,
    input wire logic [7:0]           usb_vector_index_byte_ff
);
    logic ev_any;
    assign ev_any = |usb_events;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_vec_pad_zero: assert property (
        usb_vector_index_byte_ff[7] == 1'b0
        && usb_vector_index_byte_ff[1:0] == 2'b00)
        else $error("vector byte padding bits not zero");
    a_rd_vector: assert property (
        reg_rd && reg_addr == uip_pkg::ADR_VECTOR
        |=> reg_rdata_ff == usb_vector_index_byte_ff)
        else $error("vector read differs from vector byte");
    a_rd_quiet: assert property (
        !reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data present without a read");
    a_fetch_pass: assert property (
        fetch_addr != uip_pkg::JUMP_LOW_ADDR
        |=> fetch_byte_ff == $past(fetch_mem_byte))
        else $error("fetch byte altered off the jump operand");
    a_wake_resume: assert property (
        !osc_run_ff && wake_pins != 2'b00 |-> ##[1:6] osc_run_ff)
        else $error("wake pin did not restart oscillator");
    a_int_cause: assert property (
        $rose(usb_int_req_ff) |-> $past(usb_req_pulse_ff, 2)
        || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt raised without shared pulse");
    a_int_clear: assert property (
        $fell(usb_int_req_ff) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt dropped without firmware write");
    a_pulse_cause: assert property (
        usb_req_pulse_ff |-> $past(ev_any, 2)
        || $past(reg_wr) || $past(reg_wr, 2))
        else $error("shared pulse without event or clear");
endmodule // uip_chk

bind uip_top uip_chk u_chk (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .usb_events(usb_events), .wake_pins(wake_pins),
    .fetch_addr(fetch_addr), .fetch_mem_byte(fetch_mem_byte),
    .fetch_byte_ff(fetch_byte_ff), .usb_int_req_ff(usb_int_req_ff),
    .usb_req_pulse_ff(usb_req_pulse_ff), .osc_run_ff(osc_run_ff),
    .usb_vector_index_byte_ff(usb_vector_index_byte_ff));
`default_nettype wire

// [tb/uip_core_mem.sv]
`timescale 1ns/10ps
`default_nettype none
// Program memory seen by the core; content varies with every address
module uip_core_mem (
    input  wire logic [15:0] fetch_addr,
    output logic      [7:0]  fetch_mem_byte
);
    assign fetch_mem_byte = fetch_addr[7:0] ^ fetch_addr[15:8] ^ 8'h5A;
endmodule // uip_core_mem
`default_nettype wire

// [tb/test_usb_interrupt_prioritizer.sv]
`timescale 1ns/10ps
`default_nettype none
module test_usb_interrupt_prioritizer;
    logic                 clock, sys_rst, reg_wr, reg_rd, sbv, bact;
    logic                 req_p, int_r, res_i, osc;
    logic [7:0]           reg_addr, reg_wdata, rdata, sbd, fbyte, fmem, vec;
    logic [2:0]           sbi;
    logic [1:0]           wake;
    logic [10:0]          sofn;
    logic [15:0]          faddr;
    logic [7:0]           vec_r, e_r;
    logic [26:0]          m;
    logic [31:0]          p, en;
    uip_pkg::uip_events_s ev;
    int                   mismatches, cmp_count, s;
    int                   npulse = 0;
    int                   np0;

    uip_top DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(rdata), .usb_events(ev), .sof_frame_number(sofn),
        .setup_byte_valid(sbv), .setup_byte_index(sbi),
        .setup_byte_data(sbd), .wake_pins(wake), .bus_activity(bact),
        .fetch_addr(faddr), .fetch_mem_byte(fmem), .fetch_byte_ff(fbyte),
        .usb_int_req_ff(int_r), .usb_req_pulse_ff(req_p),
        .resume_int_ff(res_i), .osc_run_ff(osc),
        .usb_vector_index_byte_ff(vec));
    uip_core_mem u_mem (.fetch_addr(faddr), .fetch_mem_byte(fmem));
    // Reduced variant sees the same stimulus
    uip_top #(.reduced_variant(1'b1)) DUT_R (.clock(clock),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(),
        .usb_events(ev), .sof_frame_number(sofn),
        .setup_byte_valid(sbv), .setup_byte_index(sbi),
        .setup_byte_data(sbd), .wake_pins(wake), .bus_activity(bact),
        .fetch_addr(faddr), .fetch_mem_byte(fmem), .fetch_byte_ff(),
        .usb_int_req_ff(), .usb_req_pulse_ff(), .resume_int_ff(),
        .osc_run_ff(), .usb_vector_index_byte_ff(vec_r));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) if (req_p) npulse <= npulse + 1;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock) chk(rdata, e);
    endtask
    task automatic wr32(input logic [7:0] base, input logic [31:0] v);
        for (int k = 0; k < 4; k++) wr(base + 8'(k), v[8*k+:8]);
    endtask
    task automatic fire(input logic [26:0] mm);
        @(posedge clock);
        ev <= uip_pkg::uip_events_s'(mm);
        @(posedge clock);
        ev <= '0;
    endtask
    // Event bit of the packed struct to its priority slot
    function automatic int slot_of(input int b);
        int tl[7] = '{6, 5, 4, 3, 1, 0, 2};
        if (b < 4) return 28 + b;
        if (b == 4) return 24;
        if (b < 11) return 13 + b;
        if (b == 11) return 16;
        if (b < 20) return b - 4;
        return tl[b-20];
    endfunction
    function automatic logic [31:0] smask(input logic [26:0] mm);
        logic [31:0] r = '0;
        for (int b = 0; b < 27; b++) if (mm[b]) r[slot_of(b)] = 1'b1;
        return r;
    endfunction
    function automatic logic [7:0] exp_vec(input logic [31:0] pp);
        for (int i = 0; i < 32; i++) if (pp[i]) return 8'(i << 2);
        return 8'h00;
    endfunction

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        conclude();
    end

    initial begin
        sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
        reg_wdata = 8'h00; ev = '0; sofn = '0; sbv = 1'b0; sbi = '0;
        sbd = 8'h00; wake = 2'b00; bact = 1'b0; faddr = 16'h0100;
        mismatches = 0; cmp_count = 0;
        void'($urandom(27205));
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'hF0, 8'h00);
        wr32(uip_pkg::ADR_EN0, 32'hFFFFFFFF);
        wr(uip_pkg::ADR_MAIN_EN, 8'h01);
        wr(uip_pkg::ADR_SETUP_CTRL, 8'h08);
        for (int b = 0; b < 27; b++) begin
            if (b == 25) continue;
            fire(27'(1) << b);
            repeat (4) @(posedge clock);
            @(negedge clock) chk({7'h00, int_r}, 8'h01);
            e_r = exp_vec(smask(27'(1) << b) & ~uip_pkg::SLOT_REDUCED);
            chk(vec_r, e_r);
            rd(uip_pkg::ADR_MAIN_FLAG, 8'h10);
            rd(uip_pkg::ADR_VECTOR, exp_vec(smask(27'(1) << b)));
            @(posedge clock) faddr <= uip_pkg::JUMP_LOW_ADDR;
            @(posedge clock) faddr <= 16'h0100;
            @(negedge clock) chk(fbyte, exp_vec(smask(27'(1) << b)));
            wr(uip_pkg::ADR_MAIN_FLAG, 8'h00);
            wr32(uip_pkg::ADR_REQ0, smask(27'(1) << b));
            rd(uip_pkg::ADR_MAIN_FLAG, 8'h00);
        end
        $display("test vectors done");
        for (int t = 0; t < 6; t++) begin
            en = $urandom;
            m = 27'($urandom) & ~(27'(1) << 25);
            wr32(uip_pkg::ADR_EN0, en);
            fire(m);
            p = smask(m) & en;
            while (p != 0) begin
                s = int'(exp_vec(p)) >> 2;
                wr(uip_pkg::ADR_MAIN_FLAG, 8'h00);
                wr(uip_pkg::ADR_REQ0 + 8'(s / 8), 8'h00);
                rd(uip_pkg::ADR_VECTOR, exp_vec(p));
                np0 = npulse;
                wr(uip_pkg::ADR_REQ0 + 8'(s / 8), 8'(1 << (s % 8)));
                p[s] = 1'b0;
                repeat (3) @(posedge clock);
                @(negedge clock) chk(8'(npulse - np0), {7'h00, p != 0});
            end
            wr32(uip_pkg::ADR_REQ0, 32'hFFFFFFFF);
        end
        wr32(uip_pkg::ADR_EN0, 32'hFFFFFFFF);
        // Event lands on the same edge as its own clear
        @(posedge clock);
        reg_addr <= uip_pkg::ADR_REQ0 + 8'h01; reg_wdata <= 8'h01;
        reg_wr <= 1'b1; ev <= uip_pkg::uip_events_s'(27'(1) << 12);
        @(posedge clock);
        reg_wr <= 1'b0; ev <= '0;
        rd(uip_pkg::ADR_REQ0 + 8'h01, 8'h01);
        wr32(uip_pkg::ADR_REQ0, 32'hFFFFFFFF);
        $display("test priority done");
        fire(27'(1) << 26);
        fire(27'(1) << 25);
        rd(uip_pkg::ADR_REQ0, 8'h04);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            sbv <= 1'b1; sbi <= 3'(i); sbd <= 8'h3C ^ 8'(i * 17);
        end
        @(posedge clock) sbv <= 1'b0;
        fire(27'(1) << 25);
        rd(uip_pkg::ADR_VECTOR, 8'h00);
        for (int i = 0; i < 8; i++)
            rd(uip_pkg::ADR_SETUP_BYTE0 + 8'(i), 8'h3C ^ 8'(i * 17));
        wr32(uip_pkg::ADR_REQ0, 32'hFFFFFFFF);
        sofn <= 11'($urandom);
        fire(27'(1) << 24);
        rd(uip_pkg::ADR_FRAME_LO, sofn[7:0]);
        rd(uip_pkg::ADR_FRAME_HI, {5'h00, sofn[10:8]});
        rd(uip_pkg::ADR_VECTOR, 8'h04);
        wr32(uip_pkg::ADR_REQ0, 32'hFFFFFFFF);
        $display("test setup and frame done");
        for (int w = 0; w < 2; w++) begin
            wr(uip_pkg::ADR_POWER, 8'h01);
            repeat (3) @(posedge clock);
            @(negedge clock) chk({7'h00, osc}, 8'h00);
            @(posedge clock);
            if (w == 0) wake <= 2'b10;
            else bact <= 1'b1;
            repeat (8) @(posedge clock);
            @(negedge clock) chk({6'h00, osc, res_i}, 8'h03);
            @(posedge clock);
            wake <= 2'b00; bact <= 1'b0;
            wr(uip_pkg::ADR_POWER, 8'h02);
            repeat (2) @(posedge clock);
            @(negedge clock) chk({7'h00, res_i}, 8'h00);
        end
        $display("test wake done");
        conclude();
    end
endmodule // test_usb_interrupt_prioritizer
`default_nettype wire
